/* include/wtoe_defs.svh */
// Overview of operation
// - Block move copies up to 40h words
// - Move: count stack1, source accumulator, destination operand
// - Oversized move count sets shared range flag
// - Label copy: count stack2, offset stack1
// - Label copy: label from accumulator, destination operand
// - Bit set forces one bit high
// - Bit clear forces one bit low
// - Bit ops: length stack1 to FFh, start accumulator
// - Bit reference indexes 16-bit words from bit 0
// - Out-of-range bit sets flag, memory untouched
// - Flag holds until scan end or next driver
// - Fill writes one value into every word
// - Fill: count stack1 to FFh, start accumulator
`ifndef WTOE_DEFS_SVH
`define WTOE_DEFS_SVH
`define WTOE_AW 16
`define WTOE_DW 16
`define WTOE_MOVE_MAX 16'h0040
`define WTOE_LEN_MSB 7
`define WTOE_WORD_SHIFT 4
`define WTOE_ONE 16'h0001
`endif

/* include/wtoe_pkg.sv */
`include "wtoe_defs.svh"
package wtoe_pkg;
    // Table operations the sequencer may issue
    typedef enum logic [2:0] {
        OP_BLOCK_MOVE,
        OP_LABEL_COPY,
        OP_BIT_SET,
        OP_BIT_CLEAR,
        OP_FILL
    } wtoe_op_t;

    // Engine sequencing states
    typedef enum logic [2:0] {
        S_IDLE, S_RD, S_WAIT, S_CAP, S_WR, S_NEXT, S_DONE
    } wtoe_state_t;

    // One issued table operation with its stack parameters
    typedef struct packed {
        wtoe_op_t op;
        logic [`WTOE_DW-1:0] acc;
        logic [`WTOE_DW-1:0] stack1;
        logic [`WTOE_DW-1:0] stack2;
        logic [`WTOE_DW-1:0] operand;
        logic operand_is_mem;
    } wtoe_cmd_t;

    // Request towards a word memory
    typedef struct packed {
        logic rd;
        logic wr;
        logic [`WTOE_AW-1:0] addr;
        logic [`WTOE_DW-1:0] wdata;
    } wtoe_mem_req_t;
endpackage

/* src/wtoe_bit_edit.sv */
`timescale 1ns/10ps
`include "wtoe_defs.svh"
module wtoe_bit_edit
    import wtoe_pkg::*;
#(
    parameter int DW = `WTOE_DW
) (
    input wire logic [DW-1:0] word_in, // Word read from the table
    input wire logic [3:0] bit_pos, // Bit inside the word
    input wire logic force_one, // Set the bit
    input wire logic force_zero, // Clear the bit
    output logic [DW-1:0] word_out // Edited word
);
    logic [DW-1:0] mask; // One-hot select of the target bit

    // Only the addressed bit changes; all others pass through
    always_comb begin
        mask = DW'(`WTOE_ONE) << bit_pos;
        word_out = word_in;
        if (force_one) begin
            word_out = word_in | mask;
        end else if (force_zero) begin
            word_out = word_in & ~mask;
        end
    end
endmodule // wtoe_bit_edit

/* src/wtoe_engine.sv */
`timescale 1ns/10ps
`include "wtoe_defs.svh"
module wtoe_engine
    import wtoe_pkg::*;
#(
    parameter logic [`WTOE_DW-1:0] MOVE_MAX = `WTOE_MOVE_MAX
) (
    input wire logic clk_sys, // 50 MHz system clock
    input wire logic sys_rst, // Synchronous reset, active high
    input wire logic start, // One-cycle issue strobe
    input wire logic rung_en, // Enabling rung condition
    input wire logic scan_end, // End of current scan pulse
    input wire wtoe_cmd_t cmd, // Operation and its parameters
    input wire logic [`WTOE_DW-1:0] dm_rdata, // Data memory read word
    input wire logic [`WTOE_DW-1:0] pm_rdata, // Program memory read word
    output wtoe_mem_req_t dm_req, // Data memory request
    output logic pm_rd, // Program memory read strobe
    output logic [`WTOE_AW-1:0] pm_addr, // Program memory address
    output logic busy, // Operation in progress
    output logic done, // Completion pulse
    output logic range_error_flag // Shared status flag
);
    wtoe_state_t state; // Sequencer state
    wtoe_op_t op; // Operation being executed
    logic [`WTOE_AW-1:0] src; // Next source address
    logic [`WTOE_AW-1:0] dst; // Next destination address
    logic [`WTOE_DW-1:0] cnt; // Words still to write
    logic [`WTOE_DW-1:0] data; // Captured word
    logic [3:0] bit_pos; // Bit within the target word
    logic from_pm; // Reads go to program memory
    logic [`WTOE_DW-1:0] edited; // Word after bit edit
    logic go; // Accepted enabled issue
    logic flag_set; // This issue raises the flag
    logic flag_drive; // This issue owns the flag
    logic wrote; // Helper: a write happened in this operation
    logic [`WTOE_DW-1:0] wr_count; // Helper: writes in this operation
    logic [`WTOE_DW-1:0] taken; // Helper: count accepted at issue

    // Bit reference beyond length*16 bits of the table
    function automatic logic bit_out_of_range(input wtoe_cmd_t c);
        logic [`WTOE_DW-1:0] limit;
        limit = `WTOE_DW'({c.stack1[`WTOE_LEN_MSB:0]}) << `WTOE_WORD_SHIFT;
        return c.operand >= limit;
    endfunction

    // Bit operations share both the range check and the word edit
    function automatic logic is_bit_op(input wtoe_op_t o);
        return (o == OP_BIT_SET) || (o == OP_BIT_CLEAR);
    endfunction

    assign go = start && rung_en && (state == S_IDLE);
    assign flag_drive = go && (cmd.op == OP_BLOCK_MOVE || is_bit_op(cmd.op));
    assign flag_set = go && ((cmd.op == OP_BLOCK_MOVE && cmd.stack1 > MOVE_MAX)
                      || (is_bit_op(cmd.op) && bit_out_of_range(cmd)));

    wtoe_bit_edit #(.DW(`WTOE_DW)) wtoe_bit_edit_i (
        .word_in(data),
        .bit_pos(bit_pos),
        .force_one(op == OP_BIT_SET),
        .force_zero(op == OP_BIT_CLEAR),
        .word_out(edited)
    );

    // Sequencer: read, wait one cycle for memory, capture, write, step
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            state <= S_IDLE;
            op <= OP_BLOCK_MOVE;
            src <= '0;
            dst <= '0;
            cnt <= '0;
            data <= '0;
            bit_pos <= '0;
            from_pm <= 1'b0;
            dm_req <= '0;
            pm_rd <= 1'b0;
            pm_addr <= '0;
            busy <= 1'b0;
            done <= 1'b0;
        end else begin
            done <= 1'b0;
            case (state)
                S_IDLE: begin
                    if (start && !rung_en) begin
                        done <= 1'b1; // Disabled rung: acknowledge, touch nothing
                    end else if (go) begin
                        busy <= 1'b1;
                        op <= cmd.op;
                        from_pm <= 1'b0;
                        state <= S_DONE;
                        case (cmd.op)
                            OP_BLOCK_MOVE: begin
                                src <= cmd.acc;
                                dst <= cmd.operand;
                                cnt <= cmd.stack1;
                                if (cmd.stack1 <= MOVE_MAX && cmd.stack1 != '0) begin
                                    state <= S_RD;
                                end
                            end
                            OP_LABEL_COPY: begin
                                src <= cmd.acc + cmd.stack1; // Label base plus offset
                                dst <= cmd.operand + cmd.stack1;
                                cnt <= cmd.stack2;
                                from_pm <= 1'b1;
                                if (cmd.stack2 != '0) begin
                                    state <= S_RD;
                                end
                            end
                            OP_FILL: begin
                                dst <= cmd.acc;
                                cnt <= {8'h00, cmd.stack1[`WTOE_LEN_MSB:0]};
                                src <= cmd.operand;
                                data <= cmd.operand; // Constant value used as is
                                if (cmd.stack1[`WTOE_LEN_MSB:0] != 8'h00) begin
                                    state <= cmd.operand_is_mem ? S_RD : S_WR;
                                end
                            end
                            default: begin
                                // Word index is the reference over 16 bits per word
                                src <= cmd.acc + (cmd.operand >> `WTOE_WORD_SHIFT);
                                dst <= cmd.acc + (cmd.operand >> `WTOE_WORD_SHIFT);
                                bit_pos <= cmd.operand[3:0];
                                cnt <= `WTOE_ONE;
                                if (!bit_out_of_range(cmd)) begin
                                    state <= S_RD; // Out of range skips memory
                                end
                            end
                        endcase
                    end
                end
                S_RD: begin
                    pm_rd <= from_pm;
                    pm_addr <= src;
                    dm_req.rd <= !from_pm;
                    dm_req.addr <= src;
                    state <= S_WAIT;
                end
                S_WAIT: begin
                    pm_rd <= 1'b0; // Memory answers the cycle after the strobe
                    dm_req.rd <= 1'b0;
                    state <= S_CAP;
                end
                S_CAP: begin
                    data <= from_pm ? pm_rdata : dm_rdata;
                    state <= S_WR;
                end
                S_WR: begin
                    dm_req.wr <= 1'b1;
                    dm_req.addr <= dst;
                    dm_req.wdata <= edited;
                    state <= S_NEXT;
                end
                S_NEXT: begin
                    dm_req.wr <= 1'b0;
                    src <= src + `WTOE_ONE;
                    dst <= dst + `WTOE_ONE;
                    cnt <= cnt - `WTOE_ONE;
                    if (cnt == `WTOE_ONE) begin
                        state <= S_DONE;
                    end else if (op == OP_FILL) begin
                        state <= S_WR; // Fill keeps its one captured value
                    end else begin
                        state <= S_RD;
                    end
                end
                S_DONE: begin
                    done <= 1'b1; // Last write already on the port
                    busy <= 1'b0;
                    state <= S_IDLE;
                end
                default: begin
                    state <= S_IDLE;
                end
            endcase
        end
    end

    // Shared flag: a raising event wins over the scan-end clear
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            range_error_flag <= 1'b0;
        end else if (flag_set) begin
            range_error_flag <= 1'b1;
        end else if (flag_drive || scan_end) begin
            range_error_flag <= 1'b0;
        end
    end

    // Helper bookkeeping read only by the checks below
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            wrote <= 1'b0;
            wr_count <= '0;
            taken <= '0;
        end else if (start && state == S_IDLE) begin
            // Any taken issue, enabled or not, starts a fresh tally
            wrote <= 1'b0;
            wr_count <= '0;
            taken <= {8'h00, cmd.stack1[`WTOE_LEN_MSB:0]};
        end else if (dm_req.wr) begin
            wrote <= 1'b1;
            wr_count <= wr_count + `WTOE_ONE;
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);

    sequence s_big_move;
        go && cmd.op == OP_BLOCK_MOVE && cmd.stack1 > MOVE_MAX;
    endsequence
    sequence s_bad_bit;
        go && is_bit_op(cmd.op) && bit_out_of_range(cmd);
    endsequence
    sequence s_good_bit;
        go && is_bit_op(cmd.op) && !bit_out_of_range(cmd) && !scan_end;
    endsequence

    a_move_limit_flag: assert property (s_big_move |-> ##2 (done && range_error_flag))
        else $error("oversized move did not finish with flag set");
    a_move_limit_nowr: assert property (s_big_move |-> (!dm_req.wr) [*3])
        else $error("oversized move wrote memory");
    a_bit_range_flag: assert property (s_bad_bit |-> ##1 range_error_flag ##1 done)
        else $error("out-of-range bit did not raise flag then finish");
    a_bit_range_nowr: assert property (s_bad_bit |-> ##1 (!dm_req.wr && !dm_req.rd) [*2])
        else $error("out-of-range bit touched memory");
    a_bit_good_clear: assert property (s_good_bit |=> !range_error_flag)
        else $error("in-range bit op left flag set");
    a_scan_end_clear: assert property (scan_end && !flag_set |=> !range_error_flag)
        else $error("scan end did not clear flag");
    a_rung_off_idle: assert property (start && !rung_en && state == S_IDLE && !scan_end
        |=> done && !busy && !dm_req.wr && $stable(range_error_flag))
        else $error("disabled rung changed state");
    a_done_after_wr: assert property (done && wrote |-> $past(dm_req.wr, 2))
        else $error("completion not two cycles after last write");
    a_bit_set_word: assert property (dm_req.wr && op == OP_BIT_SET
        |-> dm_req.wdata[bit_pos] && $countones(dm_req.wdata ^ data) <= 1)
        else $error("bit set wrote a wrong word");
    a_bit_clr_word: assert property (dm_req.wr && op == OP_BIT_CLEAR
        |-> !dm_req.wdata[bit_pos] && $countones(dm_req.wdata ^ data) <= 1)
        else $error("bit clear wrote a wrong word");
    a_fill_count: assert property (done && busy == 1'b0 && op == OP_FILL && $past(busy)
        |-> wr_count == taken)
        else $error("fill wrote a wrong number of words");
endmodule // wtoe_engine

/* verification/test_word_table_operation_engine.sv */
`timescale 1ns/10ps
module test_word_table_operation_engine
    import wtoe_pkg::*;
;
    logic clk_sys = 1'b0; // 50 MHz clock
    logic sys_rst = 1'b1; // Synchronous reset
    logic start = 1'b0; // Issue strobe
    logic rung_en = 1'b0; // Rung condition
    logic scan_end = 1'b0; // End of scan pulse
    wtoe_cmd_t cmd = '0; // Issued command
    logic [15:0] dm_rdata; // Data memory read word
    logic [15:0] pm_rdata; // Label area read word
    wtoe_mem_req_t dm_req; // Data memory request
    logic pm_rd; // Label read strobe
    logic [15:0] pm_addr; // Label address
    logic busy; // Engine busy
    logic done; // Completion pulse
    logic range_error_flag; // Shared status flag
    int err_count = 0; // Mismatches
    int num_checks = 0; // Comparisons made
    int cyc = 0; // Cycle counter for the hang limit
    logic [31:0] seed = 32'h30A9; // Random source state
    logic [15:0] shd [0:255]; // Expected data memory image
    logic [31:0] wr_q [$]; // Expected writes {addr, data}
    logic fl_q [$]; // Expected flag at each done
    logic flg = 1'b0; // Expected flag level now

    wtoe_engine wtoe_engine_i (.clk_sys(clk_sys), .sys_rst(sys_rst), .start(start),
        .rung_en(rung_en), .scan_end(scan_end), .cmd(cmd), .dm_rdata(dm_rdata),
        .pm_rdata(pm_rdata), .dm_req(dm_req), .pm_rd(pm_rd), .pm_addr(pm_addr),
        .busy(busy), .done(done), .range_error_flag(range_error_flag));
    wtoe_mem_model wtoe_mem_model_i (.clk_sys(clk_sys), .dm_req(dm_req), .pm_rd(pm_rd),
        .pm_addr(pm_addr), .dm_rdata(dm_rdata), .pm_rdata(pm_rdata));

    // Free-running clock
    always #10 clk_sys = ~clk_sys;

    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("Error t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic final_report();
        if (err_count == 0 && num_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // Note one expected write and update the image
    task automatic exp_wr(input logic [15:0] a, input logic [15:0] d);
        wr_q.push_back({a, d});
        shd[a[7:0]] = d;
    endtask

    // Predict the outcome, issue the command, then wait for done under a bound
    task automatic issue(input wtoe_op_t op, input logic [15:0] acc, input logic [15:0] s1,
                         input logic [15:0] s2, input logic [15:0] opd, input logic mem,
                         input logic rung);
        logic [15:0] v;
        logic [15:0] w;
        int n;
        @(posedge clk_sys); // Watcher has finished the previous done by now
        v = mem ? shd[opd[7:0]] : opd;
        w = acc + (opd >> 4);
        if (rung) begin // Disabled rung predicts nothing
            case (op)
                OP_BLOCK_MOVE: begin
                    flg = (s1 > 16'h0040);
                    for (int k = 0; k < s1 && !flg; k++) begin
                        exp_wr(opd + 16'(k), shd[8'(acc + 16'(k))]);
                    end
                end
                OP_LABEL_COPY: begin
                    for (int k = 0; k < s2; k++) begin
                        exp_wr(opd + s1 + 16'(k), wtoe_mem_model_i.pm[8'(acc + s1 + 16'(k))]);
                    end
                end
                OP_FILL: begin
                    for (int k = 0; k < s1[7:0]; k++) begin
                        exp_wr(acc + 16'(k), v);
                    end
                end
                default: begin
                    flg = (opd >= {4'h0, s1[7:0], 4'h0});
                    if (!flg && op == OP_BIT_SET) begin
                        exp_wr(w, shd[w[7:0]] | (16'h0001 << opd[3:0]));
                    end else if (!flg) begin
                        exp_wr(w, shd[w[7:0]] & ~(16'h0001 << opd[3:0]));
                    end
                end
            endcase
        end
        fl_q.push_back(flg);
        start <= 1'b1;
        rung_en <= rung;
        cmd <= '{op, acc, s1, s2, opd, mem};
        @(posedge clk_sys);
        start <= 1'b0;
        n = 0;
        do begin
            @(negedge clk_sys);
            n++;
            if (n == 1) begin
                check(busy, 32'(rung));
            end
        end while (done !== 1'b1 && n < 2000);
        check(32'(done), 32'h1);
    endtask

    // Watcher: each write and each done takes the oldest note
    always @(negedge clk_sys) begin
        if (!sys_rst && dm_req.wr === 1'b1) begin // Unexpected writes always mismatch
            check({dm_req.addr, dm_req.wdata}, wr_q.size() > 0 ? wr_q.pop_front() : ~{dm_req.addr, dm_req.wdata});
        end
        if (!sys_rst && done === 1'b1) begin
            check(32'(wr_q.size()), 32'h0);
            check(busy, 32'h0);
            check(range_error_flag, fl_q.size() > 0 ? fl_q.pop_front() : ~range_error_flag);
        end
    end

    // Hang limit, far above the longest expected run
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 20000) begin
            err_count++;
            final_report();
        end
    end

    // Main sequence; all addresses handed over already in hex
    initial begin
        for (int i = 0; i < 256; i++) begin
            seed = lfsr(seed);
            wtoe_mem_model_i.dm[i] = seed[15:0];
            shd[i] = seed[15:0];
            wtoe_mem_model_i.pm[i] = seed[31:16];
        end
        repeat (12) @(posedge clk_sys);
        sys_rst <= 1'b0;
        issue(OP_BLOCK_MOVE, 16'h0010, 16'h0040, 16'h0000, 16'h0080, 1'b0, 1'b1);
        issue(OP_BLOCK_MOVE, 16'h0010, 16'h0041, 16'h0000, 16'h0080, 1'b0, 1'b1);
        // Scan end drops the flag
        @(posedge clk_sys);
        scan_end <= 1'b1;
        @(posedge clk_sys);
        scan_end <= 1'b0;
        @(negedge clk_sys);
        check(range_error_flag, 1'b0);
        flg = 1'b0;
        issue(OP_BLOCK_MOVE, 16'h0020, 16'h0000, 16'h0000, 16'h0090, 1'b0, 1'b1);
        issue(OP_LABEL_COPY, 16'h0030, 16'h0002, 16'h0003, 16'h00C0, 1'b0, 1'b1);
        issue(OP_BIT_SET, 16'h00D0, 16'h0002, 16'h0000, 16'h001C, 1'b0, 1'b1);
        issue(OP_BIT_CLEAR, 16'h00D0, 16'h0002, 16'h0000, 16'h001F, 1'b0, 1'b1);
        issue(OP_BIT_SET, 16'h00D0, 16'h0002, 16'h0000, 16'h0020, 1'b0, 1'b1);
        issue(OP_FILL, 16'h0000, 16'h00FF, 16'h0000, 16'hA5A5, 1'b0, 1'b0);
        // Random references around the edge of a three word table
        for (int i = 0; i < 12; i++) begin
            seed = lfsr(seed);
            issue(seed[0] ? OP_BIT_SET : OP_BIT_CLEAR, 16'h00E0, 16'h0003, 16'h0000,
                  {10'h000, seed[21:16]}, 1'b0, 1'b1);
        end
        seed = lfsr(seed);
        issue(OP_FILL, 16'h0000, 16'h00FF, 16'h0000, seed[15:0], 1'b0, 1'b1);
        issue(OP_FILL, 16'h0040, 16'h0004, 16'h0000, 16'h00F0, 1'b1, 1'b1);
        repeat (4) @(posedge clk_sys);
        check(32'(wr_q.size() + fl_q.size()), 32'h0);
        final_report();
    end
endmodule // test_word_table_operation_engine

/* verification/wtoe_mem_model.sv */
`timescale 1ns/10ps
`include "wtoe_defs.svh"
module wtoe_mem_model
    import wtoe_pkg::*;
(
    input wire logic clk_sys, // System clock
    input wire wtoe_mem_req_t dm_req, // Data memory request
    input wire logic pm_rd, // Label area read strobe
    input wire logic [`WTOE_AW-1:0] pm_addr, // Label area address
    output logic [`WTOE_DW-1:0] dm_rdata, // Data word, valid one cycle after read
    output logic [`WTOE_DW-1:0] pm_rdata // Label word, valid one cycle after read
);
    logic [`WTOE_DW-1:0] dm [0:255]; // Data memory, aliases every 256 words
    logic [`WTOE_DW-1:0] pm [0:255]; // Label area, read only

    // Known start so the toggling below does not stay unknown
    initial begin
        dm_rdata = 16'h0000;
        pm_rdata = 16'h0000;
    end

    // Read data stands one cycle only; it toggles otherwise so stale words never look valid
    always @(posedge clk_sys) begin
        if (dm_req.rd) begin
            dm_rdata <= dm[dm_req.addr[7:0]];
        end else begin
            dm_rdata <= ~dm_rdata;
        end
        if (dm_req.wr) begin // Word write
            dm[dm_req.addr[7:0]] <= dm_req.wdata;
        end
        if (pm_rd) begin
            pm_rdata <= pm[pm_addr[7:0]];
        end else begin
            pm_rdata <= ~pm_rdata;
        end
    end
endmodule // wtoe_mem_model
